//--- hw/usb_config_request_handler.sv
/*
 * Endpoint-zero handler for configuration, alternate-setting, address
 * and sync-frame standard requests. Holds the function address.
 * Assumes SETUP bytes arrive whole with a one-cycle strobe, and that other
 * endpoint-zero handlers take any request passed on through the pass port.
 */
// Function
// (RULE_01) Set configuration stores setup byte two.
// (RULE_02) One configuration byte held at a time.
// (RULE_03) Core logic takes no automatic endpoint action; here set interface pulses toggle reset, busy clear and re-arm itself.
// (RULE_04) Set configuration ends with handshake release.
// (RULE_05) Get configuration returns one byte, count one.
// (RULE_06) Set interface stores alt setting per interface.
// (RULE_07) Set interface resets toggles, then releases.
// (RULE_08) Set interface clears IN endpoint busy flags.
// (RULE_09) Set interface re-arms OUT endpoint byte counts.
// (RULE_10) Get interface returns alternate setting byte.
// (RULE_11) Address zero until set address arrives.
// (RULE_12) Address holds until detach or bus reset.
// (RULE_13) CPU cannot write the function address.
// (RULE_14) Re-enumeration clears function address to zero.
// (RULE_15) Sync frame selects iso OUT/IN endpoints.
// (RULE_16) Sync frame returns future frame number.
// (RULE_17) Per-endpoint sequence reset in sync frame.
// (RULE_18) Endpoints belong to only one interface.
// (RULE_19) Frame count is eleven bits, wraps.
// (RULE_20) Unmatched setups pass on unchanged.
`timescale 1ns/10ps
module usb_config_request_handler (
    input wire logic CLOCK,
    input wire logic RST,
    input wire logic SETUP_VALID,
    input wire logic [63:0] SETUP_DATA,
    input wire logic BUS_RESET,
    input wire logic DETACH,
    input wire logic RE_ENUMERATE,
    input wire logic SOF,
    input wire logic [7:0] FRAME_COUNT_LOW,
    input wire logic [2:0] FRAME_COUNT_HIGH,
    input wire logic [15:0] ISO_ADVANCE,
    input wire logic [63:0] IFACE_IN_EP_MAP,
    input wire logic [63:0] IFACE_OUT_EP_MAP,
    input wire logic FW_DONE,
    output logic [6:0] FUNCTION_ADDRESS_REG,
    output logic [7:0] CONFIG_VALUE,
    output logic [31:0] ALT_SETTING_NUMBER,
    output logic CONFIG_CHANGED,
    output logic IFACE_CHANGED,
    output logic [1:0] IFACE_INDEX,
    output logic [15:0] TOGGLE_RESET,
    output logic [15:0] IN_BUSY_CLEAR,
    output logic [15:0] OUT_REARM,
    output logic [15:0] CTRL_IN_BUFFER,
    output logic [7:0] CTRL_IN_BYTE_COUNT,
    output logic CTRL_IN_LOAD,
    output logic HANDSHAKE_NAK_HOLD,
    output logic HANDSHAKE_RELEASE,
    output logic PASS_VALID,
    output logic [63:0] PASS_DATA,
    output logic [127:0] ISO_SEQ
);
    // --------------------
    // Types and state
    // --------------------
    typedef enum logic [2:0] {
        IDLE,
        WAIT_FW,
        RELEASE
    } phase_e;

    typedef struct packed {
        phase_e phase;
        logic [6:0] address;
        logic [7:0] config_value;
        logic [31:0] alt;
        logic config_changed;
        logic iface_changed;
        logic [1:0] iface_index;
        logic [15:0] toggle_reset;
        logic [15:0] in_busy_clear;
        logic [15:0] out_rearm;
        logic [15:0] in_buffer;
        logic [7:0] in_count;
        logic in_load;
        logic nak_hold;
        logic release_pulse;
        logic pass_valid;
        logic [63:0] pass_data;
        logic sync_arm;
        logic [3:0] sync_index;
        logic [10:0] sync_frame;
    } ctrl_state_s;

    ctrl_state_s state;
    ctrl_state_s next_state;

    logic [7:0] req_type;
    logic [7:0] req_code;
    logic [7:0] value_low;
    logic [7:0] index_low;
    logic [15:0] req_len;
    logic [10:0] frame_now;
    logic [10:0] frame_future;
    logic [1:0] iface_sel;

    // Match both the type and code bytes and the expected length.
    function automatic logic req_match(input logic [7:0] rt, input logic [7:0] rc,
                                       input logic [15:0] len,
                                       input logic [7:0] want_rt,
                                       input logic [7:0] want_rc,
                                       input logic [15:0] want_len);
        req_match = (rt == want_rt) && (rc == want_rc) && (len == want_len);
    endfunction

    // Map an isochronous endpoint code to a counter slot, OUT in 0..7.
    function automatic logic [4:0] iso_slot(input logic [7:0] ep);
        if (ep >= cfg_req_pkg::ISO_OUT_LO && ep <= cfg_req_pkg::ISO_OUT_HI) begin
            iso_slot = {2'b10, ep[2:0]};
        end else if (ep >= cfg_req_pkg::ISO_IN_LO && ep <= cfg_req_pkg::ISO_IN_HI) begin
            iso_slot = {2'b11, ep[2:0]};
        end else begin
            iso_slot = 5'h00;
        end
    endfunction

    // --------------------
    // Setup field extraction
    // --------------------
    // Byte 0 sits in the low lane of the setup word.
    assign req_type = SETUP_DATA[7:0];
    assign req_code = SETUP_DATA[15:8];
    assign value_low = SETUP_DATA[23:16];
    assign index_low = SETUP_DATA[39:32];
    assign req_len = SETUP_DATA[63:48];
    assign iface_sel = index_low[1:0];
    assign frame_now = {FRAME_COUNT_HIGH, FRAME_COUNT_LOW}; // RULE_19
    // Addition at the frame width wraps modulo the frame space for free.
    assign frame_future = frame_now + cfg_req_pkg::SYNC_LEAD; // RULE_16 RULE_19

    // --------------------
    // Request decode and sequencing
    // --------------------
    // One-cycle pulses are cleared every cycle and re-raised by the request.
    always_comb begin
        logic [4:0] slot;
        slot = iso_slot(index_low);
        next_state = state;
        next_state.config_changed = 1'b0;
        next_state.iface_changed = 1'b0;
        next_state.toggle_reset = '0;
        next_state.in_busy_clear = '0;
        next_state.out_rearm = '0;
        next_state.in_load = 1'b0;
        next_state.release_pulse = 1'b0;
        next_state.pass_valid = 1'b0;
        next_state.sync_arm = 1'b0;
        case (state.phase)
            IDLE: begin
                if (SETUP_VALID) begin
                    next_state.nak_hold = 1'b1;
                    if (req_match(req_type, req_code, req_len, cfg_req_pkg::RT_OUT_DEVICE,
                                  cfg_req_pkg::RC_SET_CONFIG, cfg_req_pkg::LEN_ZERO)) begin
                        // A single byte replaces the whole configuration.
                        next_state.config_value = value_low; // RULE_01 RULE_02
                        next_state.config_changed = 1'b1; // RULE_03
                        next_state.phase = WAIT_FW;
                    end else if (req_match(req_type, req_code, req_len,
                                           cfg_req_pkg::RT_IN_DEVICE,
                                           cfg_req_pkg::RC_GET_CONFIG,
                                           cfg_req_pkg::LEN_ONE)) begin
                        next_state.in_buffer = {8'h00, state.config_value}; // RULE_05
                        next_state.in_count = cfg_req_pkg::BC_ONE; // RULE_05
                        next_state.in_load = 1'b1;
                        next_state.phase = RELEASE;
                    end else if (req_match(req_type, req_code, req_len,
                                           cfg_req_pkg::RT_OUT_DEVICE,
                                           cfg_req_pkg::RC_SET_IFACE,
                                           cfg_req_pkg::LEN_ZERO)) begin
                        next_state.alt[iface_sel*8 +: 8] = value_low; // RULE_06
                        next_state.iface_index = iface_sel;
                        next_state.iface_changed = 1'b1; // RULE_03
                        // Each endpoint lies in one map only, so no other
                        // interface is disturbed.
                        next_state.toggle_reset = IFACE_IN_EP_MAP[iface_sel*16 +: 16]
                            | IFACE_OUT_EP_MAP[iface_sel*16 +: 16]; // RULE_07 RULE_18
                        next_state.in_busy_clear = IFACE_IN_EP_MAP[iface_sel*16 +: 16]; // RULE_08
                        next_state.out_rearm = IFACE_OUT_EP_MAP[iface_sel*16 +: 16]; // RULE_09
                        next_state.phase = WAIT_FW;
                    end else if (req_match(req_type, req_code, req_len,
                                           cfg_req_pkg::RT_IN_IFACE,
                                           cfg_req_pkg::RC_GET_IFACE,
                                           cfg_req_pkg::LEN_ONE)) begin
                        next_state.in_buffer = {8'h00, state.alt[iface_sel*8 +: 8]}; // RULE_10
                        next_state.in_count = cfg_req_pkg::BC_ONE;
                        next_state.in_load = 1'b1;
                        next_state.phase = RELEASE;
                    end else if (req_match(req_type, req_code, req_len,
                                           cfg_req_pkg::RT_OUT_DEVICE,
                                           cfg_req_pkg::RC_SET_ADDRESS,
                                           cfg_req_pkg::LEN_ZERO)) begin
                        next_state.address = value_low[6:0]; // RULE_11 RULE_13
                        next_state.phase = RELEASE;
                    end else if (req_match(req_type, req_code, req_len,
                                           cfg_req_pkg::RT_IN_ENDPOINT,
                                           cfg_req_pkg::RC_SYNC_FRAME,
                                           cfg_req_pkg::LEN_TWO) && slot[4]) begin
                        next_state.in_buffer = {5'h00, frame_future}; // RULE_16
                        next_state.in_count = cfg_req_pkg::BC_TWO;
                        next_state.in_load = 1'b1;
                        next_state.sync_arm = 1'b1; // RULE_15 RULE_17
                        next_state.sync_index = slot[3:0];
                        next_state.sync_frame = frame_future;
                        next_state.phase = RELEASE;
                    end else begin
                        // Not ours: hand it on untouched and leave the NAK alone.
                        next_state.nak_hold = state.nak_hold;
                        next_state.pass_valid = 1'b1; // RULE_20
                        next_state.pass_data = SETUP_DATA; // RULE_20
                    end
                end
            end
            WAIT_FW: begin
                // Firmware re-initialises endpoints before status is released.
                if (FW_DONE) begin
                    next_state.phase = RELEASE; // RULE_03
                end
            end
            RELEASE: begin
                next_state.nak_hold = 1'b0; // RULE_04 RULE_07 RULE_10
                next_state.release_pulse = 1'b1;
                next_state.phase = IDLE;
            end
            default: begin
                next_state.phase = IDLE;
            end
        endcase
        // Loss of address takes priority over any request in flight.
        if (BUS_RESET || DETACH || RE_ENUMERATE) begin
            next_state.address = cfg_req_pkg::ADDR_RESET; // RULE_12 RULE_14
        end
    end

    // --------------------
    // State register
    // --------------------
    always_ff @(posedge CLOCK) begin
        if (RST) begin
            state <= '0;
            state.phase <= IDLE;
            state.address <= cfg_req_pkg::ADDR_RESET; // RULE_11
            state.config_value <= cfg_req_pkg::CFG_RESET;
        end else begin
            state <= next_state;
        end
    end

    // --------------------
    // Sequence counters
    // --------------------
    iso_seq_counters u_seq (
        .CLOCK(CLOCK),
        .RST(RST),
        .arm(state.sync_arm),
        .arm_index(state.sync_index),
        .arm_frame(state.sync_frame),
        .sof(SOF),
        .frame(frame_now),
        .advance(ISO_ADVANCE),
        .seq(ISO_SEQ)
    );

    // --------------------
    // Outputs, all straight from state
    // --------------------
    assign FUNCTION_ADDRESS_REG = state.address;
    assign CONFIG_VALUE = state.config_value;
    assign ALT_SETTING_NUMBER = state.alt;
    assign CONFIG_CHANGED = state.config_changed;
    assign IFACE_CHANGED = state.iface_changed;
    assign IFACE_INDEX = state.iface_index;
    assign TOGGLE_RESET = state.toggle_reset;
    assign IN_BUSY_CLEAR = state.in_busy_clear;
    assign OUT_REARM = state.out_rearm;
    assign CTRL_IN_BUFFER = state.in_buffer;
    assign CTRL_IN_BYTE_COUNT = state.in_count;
    assign CTRL_IN_LOAD = state.in_load;
    assign HANDSHAKE_NAK_HOLD = state.nak_hold;
    assign HANDSHAKE_RELEASE = state.release_pulse;
    assign PASS_VALID = state.pass_valid;
    assign PASS_DATA = state.pass_data;
endmodule

//--- hw/cfg_req_pkg.sv
/*
 * Shared constants for the endpoint-zero configuration request handler:
 * request type and code values, request lengths, field widths, ranges and
 * reset values. Assumes a byte-wide setup buffer view on the core side.
 */
package cfg_req_pkg;
    // ------------------------------------------------------------------
    // Request type and request code values
    // ------------------------------------------------------------------
    localparam logic [7:0] RT_OUT_DEVICE = 8'h00;
    localparam logic [7:0] RT_IN_DEVICE = 8'h80;
    localparam logic [7:0] RT_IN_IFACE = 8'h81;
    localparam logic [7:0] RT_IN_ENDPOINT = 8'h82;
    localparam logic [7:0] RC_GET_CONFIG = 8'h08;
    localparam logic [7:0] RC_SET_CONFIG = 8'h09;
    localparam logic [7:0] RC_GET_IFACE = 8'h0A;
    localparam logic [7:0] RC_SET_IFACE = 8'h0B;
    localparam logic [7:0] RC_SET_ADDRESS = 8'h05;
    localparam logic [7:0] RC_SYNC_FRAME = 8'h0C;
    // ------------------------------------------------------------------
    // Lengths, widths and ranges
    // ------------------------------------------------------------------
    localparam logic [15:0] LEN_ZERO = 16'h0000;
    localparam logic [15:0] LEN_ONE = 16'h0001;
    localparam logic [15:0] LEN_TWO = 16'h0002;
    localparam logic [7:0] BC_ONE = 8'h01;
    localparam logic [7:0] BC_TWO = 8'h02;
    localparam int NUM_IFACE = 4;
    localparam int IFACE_W = 2;
    localparam int NUM_EP = 16;
    localparam int NUM_ISO = 16;
    localparam int FRAME_W = 11;
    localparam logic [10:0] SYNC_LEAD = 11'h014;
    localparam logic [7:0] ISO_OUT_LO = 8'h08;
    localparam logic [7:0] ISO_OUT_HI = 8'h0F;
    localparam logic [7:0] ISO_IN_LO = 8'h88;
    localparam logic [7:0] ISO_IN_HI = 8'h8F;
    localparam logic [6:0] ADDR_RESET = 7'h00;
    localparam logic [7:0] CFG_RESET = 8'h00;
    localparam logic [7:0] SEQ_FIRST = 8'h01;
endpackage

//--- hw/iso_seq_counters.sv
/*
 * Per-endpoint isochronous packet sequence counters. Each armed endpoint
 * reloads its counter to the first value when the agreed frame arrives.
 * Assumes frame number and frame strobe are synchronous to CLOCK.
 */
`timescale 1ns/10ps
module iso_seq_counters (
    input wire logic CLOCK,
    input wire logic RST,
    input wire logic arm,
    input wire logic [3:0] arm_index,
    input wire logic [10:0] arm_frame,
    input wire logic sof,
    input wire logic [10:0] frame,
    input wire logic [15:0] advance,
    output logic [127:0] seq
);
    typedef struct packed {
        logic [15:0] armed;
        logic [175:0] target;
        logic [127:0] count;
    } seq_state_s;

    seq_state_s state;
    seq_state_s next_state;

    // ------------------------------------------------------------------
    // Counter update
    // ------------------------------------------------------------------
    // Each endpoint keeps its own counter so that syncing one never
    // disturbs another.
    always_comb begin
        next_state = state;
        for (int i = 0; i < cfg_req_pkg::NUM_ISO; i++) begin
            if (advance[i]) begin
                next_state.count[i*8 +: 8] = state.count[i*8 +: 8] + 8'h01;
            end
            if (sof && state.armed[i] && frame == state.target[i*11 +: 11]) begin
                next_state.count[i*8 +: 8] = cfg_req_pkg::SEQ_FIRST; // RULE_17
                next_state.armed[i] = 1'b0;
            end
        end
        if (arm) begin
            next_state.armed[arm_index] = 1'b1;
            next_state.target[arm_index*11 +: 11] = arm_frame;
        end
    end

    // State register.
    always_ff @(posedge CLOCK) begin
        if (RST) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    assign seq = state.count;
endmodule

//--- dv/usb_config_request_handler_assertions.sv
/*
 * Port checker for the endpoint-zero configuration request handler.
 * Assumes endpoint maps and frame count stay still while a request is open.
 */
`timescale 1ns/10ps
module usb_config_request_handler_chk (
    input logic CLOCK,
    input logic RST,
    input logic SETUP_VALID,
    input logic [63:0] SETUP_DATA,
    input logic BUS_RESET,
    input logic DETACH,
    input logic RE_ENUMERATE,
    input logic [7:0] FRAME_COUNT_LOW,
    input logic [2:0] FRAME_COUNT_HIGH,
    input logic [63:0] IFACE_IN_EP_MAP,
    input logic [63:0] IFACE_OUT_EP_MAP,
    input logic FW_DONE,
    input logic [6:0] FUNCTION_ADDRESS_REG,
    input logic [7:0] CONFIG_VALUE,
    input logic [31:0] ALT_SETTING_NUMBER,
    input logic CONFIG_CHANGED,
    input logic IFACE_CHANGED,
    input logic [1:0] IFACE_INDEX,
    input logic [15:0] IN_BUSY_CLEAR,
    input logic [15:0] OUT_REARM,
    input logic [15:0] CTRL_IN_BUFFER,
    input logic [7:0] CTRL_IN_BYTE_COUNT,
    input logic CTRL_IN_LOAD,
    input logic HANDSHAKE_NAK_HOLD,
    input logic HANDSHAKE_RELEASE
);
    // --------------------
    // Request decode
    // --------------------
    // A request is taken only while no other one is open.
    wire take = SETUP_VALID && !HANDSHAKE_NAK_HOLD && !HANDSHAKE_RELEASE;
    wire [31:0] trl = {SETUP_DATA[7:0], SETUP_DATA[15:8], SETUP_DATA[63:48]};
    wire set_cfg = take && trl == 32'h0009_0000;
    wire get_cfg = take && trl == 32'h8008_0001;
    wire set_if = take && trl == 32'h000B_0000;
    wire get_if = take && trl == 32'h810A_0001;
    wire set_adr = take && trl == 32'h0005_0000;
    wire sync = take && trl == 32'h820C_0002 && SETUP_DATA[38:35] == 4'h1;
    wire clr = BUS_RESET || DETACH || RE_ENUMERATE;
    logic wait_fw;
    logic [1:0] last_if;
    // Tracks an open set request for the release timing.
    always_ff @(posedge CLOCK) begin
        wait_fw <= !RST && !HANDSHAKE_RELEASE && (wait_fw || set_cfg || set_if);
        last_if <= SETUP_DATA[33:32];
    end
    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (RST);
    property p_set_cfg; set_cfg |=> CONFIG_VALUE == $past(SETUP_DATA[23:16]); endproperty
    a_set_cfg: assert property (p_set_cfg) else $error("config not stored");
    property p_fw_rel; wait_fw && FW_DONE |-> ##2 HANDSHAKE_RELEASE; endproperty
    a_fw_rel: assert property (p_fw_rel) else $error("no release after firmware");
    property p_get_cfg; get_cfg |=> CTRL_IN_LOAD && CTRL_IN_BUFFER[7:0] == CONFIG_VALUE
        && CTRL_IN_BYTE_COUNT == 8'h01 ##1 HANDSHAKE_RELEASE; endproperty
    a_get_cfg: assert property (p_get_cfg) else $error("bad config answer");
    property p_set_if; set_if |=> IFACE_INDEX == $past(SETUP_DATA[33:32])
        && ALT_SETTING_NUMBER[IFACE_INDEX*8+:8] == $past(SETUP_DATA[23:16]); endproperty
    a_set_if: assert property (p_set_if) else $error("alt setting not stored");
    property p_if_eps; set_if |=> IN_BUSY_CLEAR == IFACE_IN_EP_MAP[IFACE_INDEX*16+:16]
        && OUT_REARM == IFACE_OUT_EP_MAP[IFACE_INDEX*16+:16]; endproperty
    a_if_eps: assert property (p_if_eps) else $error("wrong endpoints");
    property p_get_if; get_if |=> CTRL_IN_BUFFER[7:0] == ALT_SETTING_NUMBER[last_if*8+:8]
        && CTRL_IN_BYTE_COUNT == 8'h01 ##1 HANDSHAKE_RELEASE; endproperty
    a_get_if: assert property (p_get_if) else $error("bad alt answer");
    property p_adr; set_adr && !clr |=> FUNCTION_ADDRESS_REG == $past(SETUP_DATA[22:16]); endproperty
    a_adr: assert property (p_adr) else $error("address not taken");
    property p_adr_clr; clr |=> FUNCTION_ADDRESS_REG == 7'h00; endproperty
    a_adr_clr: assert property (p_adr_clr) else $error("address not cleared");
    property p_adr_keep; !set_adr && !clr |=> $stable(FUNCTION_ADDRESS_REG); endproperty
    a_adr_keep: assert property (p_adr_keep) else $error("address moved");
    property p_sync; sync |=> CTRL_IN_BYTE_COUNT == 8'h02 && CTRL_IN_BUFFER[10:0] ==
        $past({FRAME_COUNT_HIGH, FRAME_COUNT_LOW}) + cfg_req_pkg::SYNC_LEAD; endproperty
    a_sync: assert property (p_sync) else $error("bad sync frame");
    property p_chg; (set_cfg |=> CONFIG_CHANGED) and (set_if |=> IFACE_CHANGED); endproperty
    a_chg: assert property (p_chg) else $error("change pulse missing");
    c_set_cfg: cover property (set_cfg ##1 HANDSHAKE_NAK_HOLD);
    c_get_if: cover property (get_if);
    c_sync: cover property (sync);
endmodule
bind usb_config_request_handler usb_config_request_handler_chk chk_i (.*);

//--- dv/host_ctrl_model.sv
/*
 * Host side of endpoint zero: one SETUP packet per go pulse, then waits
 * for the handshake release or for the request to be passed on.
 */
`timescale 1ns/10ps
module host_ctrl_model (
    input logic CLOCK,
    input logic RST,
    input logic go,
    input logic [63:0] setup_in,
    input logic HANDSHAKE_RELEASE,
    input logic PASS_VALID,
    output logic SETUP_VALID,
    output logic [63:0] SETUP_DATA,
    output logic done,
    output logic passed
);
    logic busy;
    // --------------------
    // Transfer sequencing
    // --------------------
    initial {SETUP_VALID, SETUP_DATA} = 65'h0;
    // One request at a time; idle data toggles so stale bytes mislead nobody.
    always @(posedge CLOCK) begin
        SETUP_VALID <= 1'b0;
        done <= 1'b0;
        SETUP_DATA <= ~SETUP_DATA;
        if (RST) begin
            busy <= 1'b0;
            passed <= 1'b0;
        end else if (go && !busy) begin
            SETUP_VALID <= 1'b1;
            SETUP_DATA <= setup_in;
            busy <= 1'b1;
        end else if (busy && (HANDSHAKE_RELEASE || PASS_VALID)) begin
            busy <= 1'b0;
            done <= 1'b1;
            passed <= PASS_VALID;
        end
    end
endmodule

//--- dv/usb_config_request_handler_tb_top.sv
/*
 * Bench for the configuration request handler: row table, then edge cases.
 * Assumes the host model and the port checker are compiled alongside.
 */
`timescale 1ns/10ps
module usb_config_request_handler_tb_top;
    typedef struct packed {logic [63:0] s; logic [31:0] e; logic [3:0] m;} row_s;
    localparam logic [63:0] IN_MAP = 64'h0030_000C_0000_0002;
    localparam logic [63:0] OUT_MAP = 64'h0300_00C0_0000_0004;
    logic CLOCK, RST, go, done, passed, SETUP_VALID, FW_DONE, SOF, BUS_RESET, DETACH;
    logic RE_ENUMERATE, CONFIG_CHANGED, IFACE_CHANGED, CTRL_IN_LOAD, HANDSHAKE_NAK_HOLD;
    logic HANDSHAKE_RELEASE, PASS_VALID;
    logic [1:0] IFACE_INDEX;
    logic [6:0] FUNCTION_ADDRESS_REG;
    logic [7:0] CONFIG_VALUE, CTRL_IN_BYTE_COUNT;
    logic [10:0] frame, tgt;
    logic [15:0] ISO_ADVANCE, TOGGLE_RESET, IN_BUSY_CLEAR, OUT_REARM, CTRL_IN_BUFFER;
    logic [15:0] seen_tog, seen_in, seen_out;
    logic [31:0] ALT_SETTING_NUMBER, mask;
    logic [63:0] SETUP_DATA, setup_in, PASS_DATA;
    logic [127:0] ISO_SEQ;
    row_s rows [10];
    int fails, cmp_count;
    host_ctrl_model host_ctrl_model_i (.*);
    usb_config_request_handler usb_config_request_handler_i (.*,
        .FRAME_COUNT_LOW(frame[7:0]), .FRAME_COUNT_HIGH(frame[10:8]),
        .IFACE_IN_EP_MAP(IN_MAP), .IFACE_OUT_EP_MAP(OUT_MAP));
    // --------------------
    // Clock, pulse collection and helpers
    // --------------------
    initial begin
        CLOCK = 1'b0;
        forever #5 CLOCK = ~CLOCK;
    end
    // One-cycle endpoint pulses are gathered per transfer.
    always @(posedge CLOCK) begin
        seen_tog <= go ? 16'h0 : seen_tog | TOGGLE_RESET;
        seen_in <= go ? 16'h0 : seen_in | IN_BUSY_CLEAR;
        seen_out <= go ? 16'h0 : seen_out | OUT_REARM;
    end
    function automatic logic [63:0] mk(input logic [7:0] t, c, v, i, input logic [15:0] l);
        return {l, 8'h00, i, 8'h00, v, c, t};
    endfunction
    task automatic check(input logic [31:0] got, exp);
        cmp_count++;
        if (got !== exp) begin
            fails++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Set configuration and set interface requests stay open until firmware is done.
    task automatic xfer(input logic [63:0] s);
        logic fw;
        fw = (s[15:0] inside {16'h0900, 16'h0B00}) && s[63:48] == 16'h0000;
        @(posedge CLOCK);
        go <= 1'b1;
        setup_in <= s;
        @(posedge CLOCK);
        go <= 1'b0;
        for (int n = 0; n < 40; n++) begin
            @(posedge CLOCK);
            FW_DONE <= fw && n == 4;
            @(negedge CLOCK);
            if (done === 1'b1) break;
        end
        check({31'h0, done}, 32'h1);
    endtask
    task automatic sof(input logic [10:0] fr, input logic [15:0] adv, input logic [7:0] exp);
        @(posedge CLOCK);
        frame <= fr;
        SOF <= adv == 16'h0;
        ISO_ADVANCE <= adv;
        @(posedge CLOCK);
        {SOF, ISO_ADVANCE} <= 17'h0;
        @(negedge CLOCK);
        check({24'h0, ISO_SEQ[87:80]}, {24'h0, exp});
    endtask
    task automatic report_and_stop;
        $display("Comparisons %0d, mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    // Sixteen transfers of under fifty cycles fit easily.
    initial begin
        repeat (3000) @(posedge CLOCK);
        fails++;
        report_and_stop();
    end
    initial begin
        {RST, go, FW_DONE, SOF, BUS_RESET, DETACH, RE_ENUMERATE} = 7'h40;
        {setup_in, ISO_ADVANCE, frame, fails, cmp_count} = '0;
        rows[0] = {mk(8'h00, 8'h09, 8'h05, 8'h00, 16'h0000), 32'h0005_0000, 4'hC};
        rows[1] = {mk(8'h80, 8'h08, 8'h00, 8'h00, 16'h0001), 32'h0005_0501, 4'hF};
        rows[2] = {mk(8'h00, 8'h0B, 8'h03, 8'h02, 16'h0000), 32'h0005_0000, 4'hC};
        rows[3] = {mk(8'h81, 8'h0A, 8'h00, 8'h02, 16'h0001), 32'h0005_0301, 4'hF};
        rows[4] = {mk(8'h81, 8'h0A, 8'h00, 8'h01, 16'h0001), 32'h0005_0001, 4'hF};
        rows[5] = {mk(8'h00, 8'h05, 8'h7F, 8'h00, 16'h0000), 32'h7F00_0000, 4'h8};
        rows[6] = {mk(8'h80, 8'h06, 8'h00, 8'h00, 16'h0012), 32'hFF05_0000, 4'hC};
        rows[7] = {mk(8'h00, 8'h09, 8'h07, 8'h00, 16'h0001), 32'hFF05_0000, 4'hC};
        rows[8] = {mk(8'h81, 8'h08, 8'h00, 8'h00, 16'h0001), 32'hFF05_0000, 4'hC};
        rows[9] = {mk(8'h82, 8'h0C, 8'h00, 8'h01, 16'h0002), 32'hFF05_0000, 4'hC};
        repeat (2) @(posedge CLOCK);
        RST <= 1'b0;
        @(negedge CLOCK);
        check({16'h0, FUNCTION_ADDRESS_REG, CONFIG_VALUE, HANDSHAKE_NAK_HOLD}, 32'h0);
        for (int r = 0; r < 10; r++) begin
            xfer(rows[r].s);
            mask = {{8{rows[r].m[3]}}, {8{rows[r].m[2]}}, {8{rows[r].m[1]}}, {8{rows[r].m[0]}}};
            check({passed, FUNCTION_ADDRESS_REG, CONFIG_VALUE, CTRL_IN_BUFFER[7:0],
                CTRL_IN_BYTE_COUNT} & mask, rows[r].e & mask);
            if (passed === 1'b1) check(PASS_DATA[31:0], rows[r].s[31:0]);
        end
        // Widest setting on the last interface; others keep theirs.
        xfer(mk(8'h00, 8'h0B, 8'hFF, 8'h03, 16'h0000));
        check({seen_in, seen_out}, {IN_MAP[63:48], OUT_MAP[63:48]});
        check({seen_tog, ALT_SETTING_NUMBER[31:16]},
            {IN_MAP[63:48] | OUT_MAP[63:48], 16'hFF03});
        xfer(mk(8'h00, 8'h09, 8'h00, 8'h00, 16'h0000));
        check({8'h00, seen_tog | seen_in | seen_out, CONFIG_VALUE}, 32'h0);
        for (int k = 0; k < 3; k++) begin
            xfer(mk(8'h00, 8'h05, 8'h2A, 8'h00, 16'h0000));
            check({25'h0, FUNCTION_ADDRESS_REG}, 32'h2A);
            @(posedge CLOCK);
            {BUS_RESET, DETACH, RE_ENUMERATE} <= 3'b001 << k;
            @(posedge CLOCK);
            {BUS_RESET, DETACH, RE_ENUMERATE} <= 3'b000;
            @(negedge CLOCK);
            check({25'h0, FUNCTION_ADDRESS_REG}, 32'h0);
        end
        // Sync near the top of the frame range must wrap.
        tgt = 11'h7F0 + cfg_req_pkg::SYNC_LEAD;
        @(posedge CLOCK);
        frame <= 11'h7F0;
        xfer(mk(8'h82, 8'h0C, 8'h00, 8'h8A, 16'h0002));
        check({13'h0, CTRL_IN_BUFFER[10:0], CTRL_IN_BYTE_COUNT}, {13'h0, tgt, 8'h02});
        sof(tgt - 11'h001, 16'h0, 8'h00);
        sof(tgt, 16'h0, 8'h01);
        sof(tgt, 16'h0400, 8'h02);
        report_and_stop();
    end
endmodule
